//--- hdl/lpa_ability_reg.sv
// Link partner ability register: base-page and next-page views at one address
//
// Overview of operation
// - Address 0x05 holds the partner's received ability word, readable by software.
// - After successful negotiation with next pages supported, next-page contents replace base page.
// - Bit 15 shows partner's next-page request in both views, reset 0.
// - Bit 14 shows partner acknowledge, driven from negotiation logic, reset 0.
// - Base view bit 13 shows partner remote fault, reset 0.
// - Base view bit 12 reserved: reads 0, software writes only 0.
// - Base view bit 11 shows partner asymmetric pause capability.
// - Base view bit 10 shows partner pause capability.
// - Base view bit 9 shows partner 100BASE-T4 capability.
// - Base view bit 8 shows partner 100BASE-TX full duplex capability.
// - Base view bit 7 shows partner 100BASE-TX half duplex capability.
// - Base view bit 6 shows partner 10BASE-T full duplex capability.
// - Base view bit 5 shows partner 10BASE-T capability.
// - Base view bits 4:0 hold partner selector as received, reset zero.
// - Next-page view sits at the same address as the base view.
// - Next view bit 13 marks message page; bits 10:0 hold code field.
// - Next view bit 12 shows partner ability to comply, reset 0.
// - Next view bit 11 holds the received toggle bit.
`timescale 1ns/10ps
module lpa_ability_reg
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire lpa_pkg::lpa_page_s page_rx,
    input wire logic partner_ack,
    input wire logic an_complete,
    input wire logic next_pages_supported,
    input wire lpa_pkg::lpa_mgmt_req_s mgmt_req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic [15:0] partner_ability_word,
    output logic next_view_active
);
    import lpa_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Field composition of the two views

    function automatic logic [15:0] base_view(input logic [15:0] w, input logic ack);
        logic [15:0] v;
        v = 16'h0000;
        v[LPA_NEXT_REQ_BIT] = w[LPA_NEXT_REQ_BIT];
        v[LPA_ACK_BIT] = ack;
        v[LPA_FAULT_BIT] = w[LPA_FAULT_BIT];
        v[LPA_RSVD_BIT] = 1'b0;
        v[LPA_ASYM_BIT] = w[LPA_ASYM_BIT];
        v[LPA_PAUSE_BIT] = w[LPA_PAUSE_BIT];
        v[LPA_T4_BIT] = w[LPA_T4_BIT];
        v[LPA_FAST_FD_BIT] = w[LPA_FAST_FD_BIT];
        v[LPA_FAST_HD_BIT] = w[LPA_FAST_HD_BIT];
        v[LPA_SLOW_FD_BIT] = w[LPA_SLOW_FD_BIT];
        v[LPA_SLOW_HD_BIT] = w[LPA_SLOW_HD_BIT];
        v[LPA_SEL_HI:LPA_SEL_LO] = w[LPA_SEL_HI:LPA_SEL_LO];
        return v;
    endfunction : base_view

    function automatic logic [15:0] next_view(input logic [15:0] w, input logic ack);
        logic [15:0] v;
        v = 16'h0000;
        v[LPA_NEXT_REQ_BIT] = w[LPA_NEXT_REQ_BIT];
        v[LPA_ACK_BIT] = ack;
        v[LPA_MSG_PAGE_BIT] = w[LPA_MSG_PAGE_BIT];
        v[LPA_COMPLY_BIT] = w[LPA_COMPLY_BIT];
        v[LPA_TOGGLE_BIT] = w[LPA_TOGGLE_BIT];
        v[LPA_CODE_HI:LPA_CODE_LO] = w[LPA_CODE_HI:LPA_CODE_LO];
        return v;
    endfunction : next_view

    ////////////////////////////////////////////////////////////////////////////
    // Page capture; the management write path never reaches these loads

    logic load_base;
    logic load_next;
    logic [15:0] base_word;
    logic [15:0] next_word;

    assign load_base = page_rx.valid && !page_rx.is_next;
    assign load_next = page_rx.valid && page_rx.is_next;

    lpa_page_capture u_base_capture
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .load(load_base),
        .keep_mask(LPA_BASE_KEEP),
        .word_in(page_rx.word),
        .word(base_word)
    );

    lpa_page_capture u_next_capture
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .load(load_next),
        .keep_mask(LPA_NEXT_KEEP),
        .word_in(page_rx.word),
        .word(next_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // View selection and acknowledge tracking

    lpa_view_e view;
    lpa_view_e next_view_sel;
    logic next_seen;
    logic next_next_seen;
    logic ack;
    logic next_ack;
    logic [15:0] shown_word;
    logic [15:0] next_partner_word;
    logic next_next_view_active;

    always_comb
    begin
        next_ack = partner_ack;
        next_next_seen = next_seen;
        next_view_sel = view;
        // A fresh base page starts a new exchange, so older next pages go stale
        if (load_base)
        begin
            next_next_seen = 1'b0;
        end
        else if (load_next)
        begin
            next_next_seen = 1'b1;
        end
        case (view)
            LPA_VIEW_BASE:
            begin
                if (an_complete && next_pages_supported && next_seen && !load_base)
                begin
                    next_view_sel = LPA_VIEW_NEXT;
                end
            end
            LPA_VIEW_NEXT:
            begin
                // Renegotiation drops completion; fall back to the base page
                if (!an_complete || !next_pages_supported || load_base)
                begin
                    next_view_sel = LPA_VIEW_BASE;
                end
            end
            default:
            begin
                next_view_sel = LPA_VIEW_BASE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            view <= LPA_VIEW_BASE;
            next_seen <= 1'b0;
            ack <= 1'b0;
        end
        else
        begin
            view <= next_view_sel;
            next_seen <= next_next_seen;
            ack <= next_ack;
        end
    end

    // Both views share one address; the state picks which one answers
    always_comb
    begin
        if (view == LPA_VIEW_NEXT)
        begin
            shown_word = next_view(next_word, ack);
        end
        else
        begin
            shown_word = base_view(base_word, ack);
        end
        next_partner_word = shown_word;
        next_next_view_active = (view == LPA_VIEW_NEXT);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            partner_ability_word <= LPA_WORD_RST;
            next_view_active <= 1'b0;
        end
        else
        begin
            partner_ability_word <= next_partner_word;
            next_view_active <= next_next_view_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Management access; write data is dropped by the read port

    lpa_read_port u_read_port
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .req(mgmt_req),
        .shown_word(shown_word),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    chk_base_load: assert property (
        load_base |=> base_word == ($past(page_rx.word) & LPA_BASE_KEEP))
        else $error("base page not captured");

    chk_next_switch: assert property (
        (view == LPA_VIEW_BASE && an_complete && next_pages_supported && next_seen && !load_base)
        |=> view == LPA_VIEW_NEXT ##1 next_view_active)
        else $error("next-page view not taken after completion");

    chk_next_req_follow: assert property (
        $past(view) == LPA_VIEW_BASE && view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_NEXT_REQ_BIT] == $past(base_word[LPA_NEXT_REQ_BIT]))
        else $error("next-page request bit wrong");

    // Two-stage lag; the first cycles after reset still show the cleared flop
    chk_ack_delay: assert property (
        $past(arst_n, 3) |-> partner_ability_word[LPA_ACK_BIT] == $past(partner_ack, 2))
        else $error("acknowledge bit did not follow input");

    chk_reserved_zero: assert property (
        !next_view_active |-> partner_ability_word[LPA_RSVD_BIT] == 1'b0)
        else $error("reserved bit read as one");

    chk_base_fields: assert property (
        view == LPA_VIEW_BASE |=> partner_ability_word[LPA_SEL_HI:LPA_SEL_LO]
        == $past(base_word[LPA_SEL_HI:LPA_SEL_LO]))
        else $error("selector field mismatch");

    chk_read_answer: assert property (
        (mgmt_req.rd && mgmt_req.addr == LPA_ABILITY_ADDR) |=> rd_valid && rd_data == $past(shown_word))
        else $error("read at ability address returned wrong word");

    chk_next_fields: assert property (
        view == LPA_VIEW_NEXT |=> partner_ability_word[LPA_CODE_HI:LPA_CODE_LO]
        == $past(next_word[LPA_CODE_HI:LPA_CODE_LO]))
        else $error("next-page code field mismatch");

    chk_write_ignored: assert property (
        (mgmt_req.wr && !page_rx.valid) |=> base_word == $past(base_word) && next_word == $past(next_word))
        else $error("write altered captured word");

    chk_unmapped_zero: assert property (
        (mgmt_req.rd && mgmt_req.addr != LPA_ABILITY_ADDR) |=> rd_valid && rd_data == LPA_UNMAPPED_DATA)
        else $error("unmapped read not zero");

    chk_view_fallback: assert property (
        (view == LPA_VIEW_NEXT && (!an_complete || !next_pages_supported)) |=> view == LPA_VIEW_BASE)
        else $error("next-page view kept after completion dropped");

    chk_fault_capture: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_FAULT_BIT] == $past(page_rx.word[LPA_FAULT_BIT], 2))
        else $error("remote fault bit not taken from base page");

    chk_asym_capture: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_ASYM_BIT] == $past(page_rx.word[LPA_ASYM_BIT], 2))
        else $error("asymmetric pause bit not taken from base page");

    chk_pause_capture: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_PAUSE_BIT] == $past(page_rx.word[LPA_PAUSE_BIT], 2))
        else $error("pause bit not taken from base page");

    chk_t4_capture: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_T4_BIT] == $past(page_rx.word[LPA_T4_BIT], 2))
        else $error("T4 bit not taken from base page");

    chk_fast_full: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_FAST_FD_BIT] == $past(page_rx.word[LPA_FAST_FD_BIT], 2))
        else $error("fast full duplex bit not taken from base page");

    chk_fast_half: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_FAST_HD_BIT] == $past(page_rx.word[LPA_FAST_HD_BIT], 2))
        else $error("fast half duplex bit not taken from base page");

    chk_slow_full: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_SLOW_FD_BIT] == $past(page_rx.word[LPA_SLOW_FD_BIT], 2))
        else $error("slow full duplex bit not taken from base page");

    chk_slow_half: assert property (
        load_base ##1 view == LPA_VIEW_BASE
        |=> partner_ability_word[LPA_SLOW_HD_BIT] == $past(page_rx.word[LPA_SLOW_HD_BIT], 2))
        else $error("slow half duplex bit not taken from base page");

    chk_comply_capture: assert property (
        load_next ##1 view == LPA_VIEW_NEXT
        |=> partner_ability_word[LPA_COMPLY_BIT] == $past(page_rx.word[LPA_COMPLY_BIT], 2))
        else $error("comply bit not taken from next page");

    chk_toggle_capture: assert property (
        load_next ##1 view == LPA_VIEW_NEXT
        |=> partner_ability_word[LPA_TOGGLE_BIT] == $past(page_rx.word[LPA_TOGGLE_BIT], 2))
        else $error("toggle bit not taken from next page");

endmodule : lpa_ability_reg

//--- hdl/lpa_pkg.sv
// Package: constants and carriers for the link partner ability register
package lpa_pkg;

    localparam logic [4:0] LPA_ABILITY_ADDR = 5'h05;
    localparam int LPA_WORD_W = 16;
    localparam int LPA_ADDR_W = 5;

    // Field positions, common to both views
    localparam int LPA_NEXT_REQ_BIT = 15;
    localparam int LPA_ACK_BIT = 14;
    // Base-page fields
    localparam int LPA_FAULT_BIT = 13;
    localparam int LPA_RSVD_BIT = 12;
    localparam int LPA_ASYM_BIT = 11;
    localparam int LPA_PAUSE_BIT = 10;
    localparam int LPA_T4_BIT = 9;
    localparam int LPA_FAST_FD_BIT = 8;
    localparam int LPA_FAST_HD_BIT = 7;
    localparam int LPA_SLOW_FD_BIT = 6;
    localparam int LPA_SLOW_HD_BIT = 5;
    localparam int LPA_SEL_HI = 4;
    localparam int LPA_SEL_LO = 0;
    // Next-page fields
    localparam int LPA_MSG_PAGE_BIT = 13;
    localparam int LPA_COMPLY_BIT = 12;
    localparam int LPA_TOGGLE_BIT = 11;
    localparam int LPA_CODE_HI = 10;
    localparam int LPA_CODE_LO = 0;

    // Reset values and unmapped read data
    localparam logic [15:0] LPA_WORD_RST = 16'h0000;
    localparam logic [15:0] LPA_RDATA_RST = 16'h0000;
    localparam logic [15:0] LPA_UNMAPPED_DATA = 16'h0000;
    // Bits that the capture registers keep; ACK is overlaid live
    localparam logic [15:0] LPA_BASE_KEEP = 16'hAFFF;
    localparam logic [15:0] LPA_NEXT_KEEP = 16'hBFFF;

    typedef enum logic {LPA_VIEW_BASE, LPA_VIEW_NEXT} lpa_view_e;

    typedef struct packed {
        logic valid;
        logic is_next;
        logic [15:0] word;
    } lpa_page_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } lpa_mgmt_req_s;

endpackage : lpa_pkg

//--- hdl/lpa_page_capture.sv
// Holding register for one received link code word
`timescale 1ns/10ps
module lpa_page_capture
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [15:0] keep_mask,
    input wire logic [15:0] word_in,
    output logic [15:0] word
);
    import lpa_pkg::*;

    logic [15:0] next_word;

    always_comb
    begin
        next_word = word;
        if (load)
        begin
            next_word = word_in & keep_mask;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            word <= LPA_WORD_RST;
        end
        else
        begin
            word <= next_word;
        end
    end

endmodule : lpa_page_capture

//--- hdl/lpa_read_port.sv
// Management read port: answers reads at the ability address, ignores writes
`timescale 1ns/10ps
module lpa_read_port
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire lpa_pkg::lpa_mgmt_req_s req,
    input wire logic [15:0] shown_word,
    output logic [15:0] rd_data,
    output logic rd_valid
);
    import lpa_pkg::*;

    logic [15:0] next_rd_data;
    logic next_rd_valid;

    always_comb
    begin
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        if (req.rd && req.addr == LPA_ABILITY_ADDR)
        begin
            next_rd_data = shown_word;
            next_rd_valid = 1'b1;
        end
        else if (req.rd)
        begin
            next_rd_data = LPA_UNMAPPED_DATA;
            next_rd_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data <= LPA_RDATA_RST;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

endmodule : lpa_read_port

//--- tb/lpa_partner_model.sv
// Behavioural model of the remote partner delivering received link code words
`timescale 1ns/10ps
module lpa_partner_model
(
    input wire logic core_clk,
    output lpa_pkg::lpa_page_s page_rx,
    output logic partner_ack
);
    import lpa_pkg::*;

    initial
    begin
        page_rx = '0;
        partner_ack = 1'b0;
    end

    // One word per call, strobed for a single cycle
    task automatic send_page(input logic is_next, input logic [15:0] word);
        @(posedge core_clk);
        page_rx <= '{valid: 1'b1, is_next: is_next, word: word};
        @(posedge core_clk);
        // The word is not held after the strobe, so show its inverse
        page_rx <= '{valid: 1'b0, is_next: ~is_next, word: ~word};
    endtask : send_page

    task automatic set_ack(input logic ack);
        @(posedge core_clk);
        partner_ack <= ack;
    endtask : set_ack

endmodule : lpa_partner_model

//--- tb/link_partner_ability_register_bench.sv
// Self-checking bench for the link partner ability register
`timescale 1ns/10ps
module link_partner_ability_register_bench;
    import lpa_pkg::*;

    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic an_complete = 1'b0;
    logic next_pages_supported = 1'b0;
    lpa_mgmt_req_s mgmt_req = '0;
    lpa_page_s page_rx;
    logic partner_ack;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] partner_ability_word;
    logic next_view_active;
    logic [15:0] shown;
    int bad_count = 0;
    int checked = 0;

    always #5 core_clk = ~core_clk;

    lpa_partner_model partner (.core_clk(core_clk), .page_rx(page_rx), .partner_ack(partner_ack));

    lpa_ability_reg uut
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .page_rx(page_rx),
        .partner_ack(partner_ack),
        .an_complete(an_complete),
        .next_pages_supported(next_pages_supported),
        .mgmt_req(mgmt_req),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .partner_ability_word(partner_ability_word),
        .next_view_active(next_view_active)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
        checked++;
        if (seen !== expected)
        begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expected);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_clk

    // Request held for one edge; reg_read then awaits the answer under a bound
    task automatic reg_access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata);
        @(posedge core_clk);
        mgmt_req <= '{rd: ~wr, wr: wr, addr: addr, wdata: wdata};
        @(posedge core_clk);
        mgmt_req <= '0;
    endtask : reg_access

    task automatic reg_read(input logic [4:0] addr, output logic [15:0] data);
        int n;
        reg_access(1'b0, addr, 16'h0000);
        #1;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 4)
        begin
            bad_count++;
            $display("mismatch at %0t: read answer timed out", $time);
            stop_test();
        end
        else
        begin
            data = rd_data;
        end
    endtask : reg_read

    task automatic expect_shown(input logic [15:0] exp, input logic view, input string what);
        logic [15:0] d;
        wait_clk(3);
        reg_read(LPA_ABILITY_ADDR, d);
        check(d, exp, what);
        check(partner_ability_word, exp, what);
        check({15'h0000, next_view_active}, {15'h0000, view}, what);
        shown = exp;
    endtask : expect_shown

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        expect_shown(LPA_WORD_RST, 1'b0, "reset value");
    endtask : test_reset

    task automatic test_base_fields();
        logic [15:0] words [4] = '{16'hFFFF, 16'h5555, 16'hAAAA, 16'h0001};
        for (int i = 0; i < 4; i++)
        begin
            partner.set_ack(i[0]);
            partner.send_page(1'b0, words[i]);
            // Reserved bit 12 reads 0, bit 14 follows the acknowledge
            expect_shown((words[i] & 16'hAFFF) | {1'b0, i[0], 14'h0000}, 1'b0, "base fields");
        end
    endtask : test_base_fields

    task automatic test_writes_ignored();
        logic [15:0] d;
        reg_access(1'b1, LPA_ABILITY_ADDR, 16'hEFFF);
        reg_access(1'b1, LPA_ABILITY_ADDR, 16'h0000);
        reg_read(LPA_ABILITY_ADDR, d);
        check(d, shown, "write ignored");
        reg_read(5'h06, d);
        check(d, LPA_UNMAPPED_DATA, "unmapped read");
        @(posedge core_clk);
        #1;
        check({15'h0000, rd_valid}, 16'h0000, "valid lasts one cycle");
    endtask : test_writes_ignored

    task automatic test_next_view();
        logic [15:0] base_w;
        base_w = shown;
        @(posedge core_clk);
        next_pages_supported <= 1'b1;
        partner.send_page(1'b1, 16'h9ABC);
        expect_shown(base_w, 1'b0, "next page before completion");
        @(posedge core_clk);
        an_complete <= 1'b1;
        expect_shown(16'hDABC, 1'b1, "next view");
        partner.send_page(1'b1, 16'h3800);
        expect_shown(16'h7800, 1'b1, "next view flags");
        partner.send_page(1'b0, 16'h0421);
        expect_shown(16'h4421, 1'b0, "base page returns");
        partner.send_page(1'b1, 16'h8000);
        expect_shown(16'hC000, 1'b1, "next view again");
        @(posedge core_clk);
        an_complete <= 1'b0;
        expect_shown(16'h4421, 1'b0, "completion dropped");
    endtask : test_next_view

    task automatic test_mid_reset();
        @(posedge core_clk);
        arst_n <= 1'b0;
        wait_clk(2);
        #1;
        check(partner_ability_word, LPA_WORD_RST, "word in reset");
        check(rd_data, LPA_RDATA_RST, "read data in reset");
        check({15'h0000, rd_valid}, 16'h0000, "valid in reset");
        check({15'h0000, next_view_active}, 16'h0000, "view in reset");
        @(posedge core_clk);
        arst_n <= 1'b1;
        // Captures are cleared; bit 14 returns from the acknowledge that stayed high
        expect_shown(16'h4000, 1'b0, "after mid-run reset");
    endtask : test_mid_reset

    task automatic test_no_support();
        @(posedge core_clk);
        an_complete <= 1'b1;
        next_pages_supported <= 1'b0;
        partner.send_page(1'b1, 16'h8123);
        expect_shown(16'h4000, 1'b0, "next page without support");
        @(posedge core_clk);
        next_pages_supported <= 1'b1;
        expect_shown(16'hC123, 1'b1, "support granted");
        @(posedge core_clk);
        next_pages_supported <= 1'b0;
        expect_shown(16'h4000, 1'b0, "support dropped");
    endtask : test_no_support

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        shown = 16'h0000;
        wait_clk(20);
        arst_n <= 1'b1;
        test_reset();
        test_base_fields();
        test_writes_ignored();
        test_next_view();
        test_mid_reset();
        test_no_support();
        stop_test();
    end

endmodule : link_partner_ability_register_bench
